/* File: shared/drp_pkg.sv */
// Purpose: Shared constants and types for the display, result and peak register group
// Assumes: 4-bit register index, 16-bit register data
// Notes:   Field positions follow the segment override register layouts
package drp_pkg;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned CONV_W   = 20;
  localparam int unsigned SUB_W    = 4;

  localparam logic [3:0] IDX_SEG_B     = 4'h0;
  localparam logic [3:0] IDX_SEG_C     = 4'h1;
  localparam logic [3:0] IDX_OFFSET    = 4'h2;
  localparam logic [3:0] IDX_CONV_UP   = 4'h3;
  localparam logic [3:0] IDX_CONV_LO   = 4'h4;
  localparam logic [3:0] IDX_DISPLAY   = 4'h5;
  localparam logic [3:0] IDX_MAX       = 4'h6;

  localparam logic [15:0] SEG_B_RST    = 16'h0000;
  localparam logic [7:0]  SEG_C_RST    = 8'h00;
  localparam logic [15:0] OFFSET_RST   = 16'h0000;
  localparam logic [19:0] CONV_RST     = 20'h0_0000;
  localparam logic [15:0] DISPLAY_RST  = 16'h0000;
  localparam logic [15:0] MAX_RST      = 16'hb1e0;
  // Don't-care bit 3 and constant bit 0 are not stored
  localparam logic [15:0] SEG_B_WMASK  = 16'hfff6;
  localparam logic [7:0]  SEG_C_WMASK  = 8'h3f;
  // Sub-bits hidden in the 3.5-digit variant
  localparam logic [15:0] SHORT_MASK   = 16'hfff0;

  localparam int unsigned POS_F_DIGIT_THREE = 15;
  localparam int unsigned POS_E_DIGIT_THREE = 14;
  localparam int unsigned POS_POINT_FOURTH  = 13;
  localparam int unsigned B_SIGN            = 12;
  localparam int unsigned POS_B_DIGIT_TWO   = 11;
  localparam int unsigned POS_C_DIGIT_TWO   = 10;
  localparam int unsigned POS_A_DIGIT_TWO   = 9;
  localparam int unsigned POS_G_DIGIT_TWO   = 8;
  localparam int unsigned POS_D_DIGIT_TWO   = 7;
  localparam int unsigned POS_F_DIGIT_TWO   = 6;
  localparam int unsigned POS_E_DIGIT_TWO   = 5;
  localparam int unsigned POS_POINT_THIRD   = 4;
  localparam int unsigned POS_B_DIGIT_ONE   = 2;
  localparam int unsigned POS_C_DIGIT_ONE   = 1;
  localparam int unsigned C_LEAD            = 5;
  localparam int unsigned POS_B_DIGIT_THREE = 4;
  localparam int unsigned POS_C_DIGIT_THREE = 3;
  localparam int unsigned POS_A_DIGIT_THREE = 2;
  localparam int unsigned POS_G_DIGIT_THREE = 1;
  localparam int unsigned POS_D_DIGIT_THREE = 0;

  // One bit per segment, high means the segment is lit
  typedef struct packed {
    logic seg_f_digit_three;
    logic seg_e_digit_three;
    logic point_segment_fourth;
    logic sign_minus;
    logic sign_plus;
    logic seg_b_digit_two;
    logic seg_c_digit_two;
    logic seg_a_digit_two;
    logic seg_g_digit_two;
    logic seg_d_digit_two;
    logic seg_f_digit_two;
    logic seg_e_digit_two;
    logic point_segment_third;
    logic seg_b_digit_one;
    logic seg_c_digit_one;
    logic seg_b_digit_three;
    logic seg_c_digit_three;
    logic seg_a_digit_three;
    logic seg_g_digit_three;
    logic seg_d_digit_three;
    logic leading_one_b;
    logic leading_one_c;
  } drp_seg_s;
endpackage

/* File: hw/drp_regs.sv */
// Purpose: Segment override, offset, result, display data and peak registers
// Assumes: Register port and control bits already decoded from the serial link
// Notes:   Read data appears one cycle after the index is presented
`timescale 1ns/1ps
module drp_regs
  import drp_pkg::*;
#(
  parameter bit FULL_DIGITS = 1'b1
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              clear_all_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              wr_en_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              conv_valid_i,
  input  wire logic [CONV_W-1:0] conv_raw_i,
  input  wire logic              segment_override_select_i,
  input  wire logic              display_source_host_i,
  input  wire logic              freeze_i,
  input  wire logic              peak_enable_i,
  output drp_seg_s               seg_lit_o,
  output logic                   numeric_enable_o,
  output logic      [DATA_W-1:0] display_value_o
);

  logic [15:0] seg_b_q, seg_b_d;
  logic [7:0]  seg_c_q, seg_c_d;
  logic [15:0] offset_q, offset_d;
  logic [19:0] conv_q, conv_d;
  logic [15:0] disp_q, disp_d;
  logic [15:0] max_q, max_d;
  logic        armed_q, armed_d;
  logic [15:0] rdata_q, rdata_d;
  drp_seg_s    seg_q, seg_d;
  logic        num_q, num_d;
  logic [15:0] dout_q, dout_d;
  logic [19:0] corr;
  logic        host_wr_disp;

  // Offset is on the upper-register scale, so it lines up above the sub-bits
  assign corr = conv_raw_i - {offset_q, 4'h0};
  assign host_wr_disp = wr_en_i && (addr_i == IDX_DISPLAY) && display_source_host_i;

  always_comb begin
    seg_b_d  = seg_b_q;
    seg_c_d  = seg_c_q;
    offset_d = offset_q;
    conv_d   = conv_q;
    disp_d   = disp_q;
    max_d    = max_q;
    armed_d  = armed_q;
    if (wr_en_i && addr_i == IDX_SEG_B) begin
      seg_b_d = wdata_i & SEG_B_WMASK;
    end
    if (wr_en_i && addr_i == IDX_SEG_C) begin
      seg_c_d = wdata_i[7:0] & SEG_C_WMASK;
    end
    if (wr_en_i && addr_i == IDX_OFFSET) begin
      offset_d = wdata_i;
    end
    if (conv_valid_i) begin
      conv_d = corr;
    end
    if (!peak_enable_i) begin
      max_d   = MAX_RST;
      armed_d = 1'b0;
    end else if (conv_valid_i) begin
      if (!armed_q) begin
        max_d   = corr[19:4];
        armed_d = 1'b1;
      end else if ($signed(corr[19:4]) > $signed(max_q)) begin
        max_d = corr[19:4];
      end
    end
    if (host_wr_disp) begin
      disp_d = wdata_i;
    end else if (!display_source_host_i && conv_valid_i && !freeze_i) begin
      // Freeze keeps the last shown value while conversions go on
      disp_d = peak_enable_i ? max_d : corr[19:4];
    end
    if (clear_all_i) begin
      seg_b_d  = SEG_B_RST;
      seg_c_d  = SEG_C_RST;
      offset_d = OFFSET_RST;
      conv_d   = CONV_RST;
      disp_d   = DISPLAY_RST;
      max_d    = MAX_RST;
      armed_d  = 1'b0;
    end
  end

  always_comb begin
    case (addr_i)
      IDX_SEG_B:   rdata_d = seg_b_q;
      IDX_SEG_C:   rdata_d = {8'h00, seg_c_q};
      IDX_OFFSET:  rdata_d = offset_q;
      IDX_CONV_UP: rdata_d = conv_q[19:4];
      IDX_CONV_LO: rdata_d = {8'h00, conv_q[3:0], 4'h0};
      IDX_DISPLAY: rdata_d = disp_q;
      IDX_MAX:     rdata_d = max_q;
      default:     rdata_d = 16'h0000;
    endcase
  end

  always_comb begin
    logic on;
    on = segment_override_select_i;
    // Segments are dark here when numeric decoding owns the display
    seg_d.seg_f_digit_three    = on & ~seg_b_q[POS_F_DIGIT_THREE];
    seg_d.seg_e_digit_three    = on & ~seg_b_q[POS_E_DIGIT_THREE];
    seg_d.point_segment_fourth = on & ~seg_b_q[POS_POINT_FOURTH];
    seg_d.sign_minus           = on & ~seg_b_q[B_SIGN];
    seg_d.sign_plus            = on &  seg_b_q[B_SIGN];
    seg_d.seg_b_digit_two      = on & ~seg_b_q[POS_B_DIGIT_TWO];
    seg_d.seg_c_digit_two      = on & ~seg_b_q[POS_C_DIGIT_TWO];
    seg_d.seg_a_digit_two      = on & ~seg_b_q[POS_A_DIGIT_TWO];
    seg_d.seg_g_digit_two      = on & ~seg_b_q[POS_G_DIGIT_TWO];
    seg_d.seg_d_digit_two      = on & ~seg_b_q[POS_D_DIGIT_TWO];
    seg_d.seg_f_digit_two      = on & ~seg_b_q[POS_F_DIGIT_TWO];
    seg_d.seg_e_digit_two      = on & ~seg_b_q[POS_E_DIGIT_TWO];
    seg_d.point_segment_third  = on & ~seg_b_q[POS_POINT_THIRD];
    seg_d.seg_b_digit_one      = on & ~seg_b_q[POS_B_DIGIT_ONE];
    seg_d.seg_c_digit_one      = on & ~seg_b_q[POS_C_DIGIT_ONE];
    seg_d.seg_b_digit_three    = on & ~seg_c_q[POS_B_DIGIT_THREE];
    seg_d.seg_c_digit_three    = on & ~seg_c_q[POS_C_DIGIT_THREE];
    seg_d.seg_a_digit_three    = on & ~seg_c_q[POS_A_DIGIT_THREE];
    seg_d.seg_g_digit_three    = on & ~seg_c_q[POS_G_DIGIT_THREE];
    seg_d.seg_d_digit_three    = on & ~seg_c_q[POS_D_DIGIT_THREE];
    seg_d.leading_one_b        = on & ~seg_c_q[C_LEAD];
    seg_d.leading_one_c        = on & ~seg_c_q[C_LEAD];
    num_d  = ~on;
    dout_d = on ? 16'h0000 : (FULL_DIGITS ? disp_q : (disp_q & SHORT_MASK));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_b_q  <= SEG_B_RST;
      seg_c_q  <= SEG_C_RST;
      offset_q <= OFFSET_RST;
      conv_q   <= CONV_RST;
      disp_q   <= DISPLAY_RST;
      max_q    <= MAX_RST;
      armed_q  <= 1'b0;
      rdata_q  <= 16'h0000;
      seg_q    <= '0;
      num_q    <= 1'b1;
      dout_q   <= 16'h0000;
    end else begin
      seg_b_q  <= seg_b_d;
      seg_c_q  <= seg_c_d;
      offset_q <= offset_d;
      conv_q   <= conv_d;
      disp_q   <= disp_d;
      max_q    <= max_d;
      armed_q  <= armed_d;
      rdata_q  <= rdata_d;
      seg_q    <= seg_d;
      num_q    <= num_d;
      dout_q   <= dout_d;
    end
  end

  assign rdata_o          = rdata_q;
  assign seg_lit_o        = seg_q;
  assign numeric_enable_o = num_q;
  assign display_value_o  = dout_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  seg_active_low_a: assert property (
    segment_override_select_i |=>
      seg_lit_o.seg_f_digit_three == !$past(seg_b_q[POS_F_DIGIT_THREE])
      && seg_lit_o.seg_d_digit_three == !$past(seg_c_q[POS_D_DIGIT_THREE]))
    else $error("override segment not active low");
  sign_select_a: assert property (
    segment_override_select_i |=> seg_lit_o.sign_plus == $past(seg_b_q[B_SIGN])
      && seg_lit_o.sign_minus != seg_lit_o.sign_plus)
    else $error("sign segment wrong");
  lead_pair_a: assert property (
    seg_lit_o.leading_one_b == seg_lit_o.leading_one_c)
    else $error("leading pair split");
  offset_sub_a: assert property (
    conv_valid_i && !clear_all_i |=> conv_q == $past(conv_raw_i) - {$past(offset_q), 4'h0})
    else $error("offset not subtracted");
  lower_read_a: assert property (
    addr_i == IDX_CONV_LO |=> rdata_o[3:0] == 4'h0 && rdata_o[7:4] == $past(conv_q[3:0]))
    else $error("lower result read wrong");
  ro_write_a: assert property (
    wr_en_i && addr_i == IDX_CONV_UP && !conv_valid_i && !clear_all_i |=> $stable(conv_q))
    else $error("read-only result changed by write");
  peak_clear_a: assert property (
    !peak_enable_i |=> max_q == MAX_RST)
    else $error("peak not cleared");
  peak_first_a: assert property (
    peak_enable_i && !armed_q && conv_valid_i && !clear_all_i |=> max_q == $past(corr[19:4]))
    else $error("first peak not copied");
  peak_grow_a: assert property (
    peak_enable_i && armed_q && !clear_all_i |=> $signed(max_q) >= $signed($past(max_q)))
    else $error("peak decreased");
  display_hidden_a: assert property (
    segment_override_select_i |=> display_value_o == 16'h0000 && !numeric_enable_o)
    else $error("display data shown under override");
  host_display_a: assert property (
    host_wr_disp && !clear_all_i |=> disp_q == $past(wdata_i))
    else $error("host display write lost");
  clear_all_a: assert property (
    clear_all_i |=> seg_b_q == SEG_B_RST && max_q == MAX_RST && conv_q == CONV_RST)
    else $error("clear-all incomplete");

  peak_track_c: cover property (peak_enable_i && armed_q && conv_valid_i ##1 $changed(max_q));
  override_c: cover property (segment_override_select_i ##1 seg_lit_o.sign_plus);
  freeze_c: cover property (freeze_i && conv_valid_i && !display_source_host_i);
  host_disp_c: cover property (host_wr_disp);

endmodule // drp_regs

/* File: verif/drp_host_model.sv */
// Purpose: Host side of the register port, one write or read per call
// Assumes: Requests change just after the rising edge
// Notes:   Released write data shows the inverse of the last value
`timescale 1ns/1ps
module drp_host_model
  import drp_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   wr_en_o,
  output logic      [DATA_W-1:0] wdata_o,
  output logic                   rd_chk_o
);
  initial begin
    addr_o = 4'h0;
    wr_en_o = 1'b0;
    wdata_o = 16'h0000;
    rd_chk_o = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wr_en_o = 1'b1;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    wdata_o = ~d;
  endtask
  // Read data is judged one edge after the index is presented
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_chk_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_chk_o = 1'b0;
  endtask
endmodule // drp_host_model

/* File: verif/display_result_peak_regs_tb.sv */
// Purpose: Self-checking bench for the display, result and peak registers
// Assumes: Full digit variant, host model on the register port
// Notes:   Expected notes queue up; the monitor pops one per result
`timescale 1ns/1ps
module display_result_peak_regs_tb
  import drp_pkg::*;
;
  typedef struct packed { logic [1:0] sel; logic [21:0] val; } drp_note_s;
  logic clk_i, rst_n_i, clear_all_i, conv_valid_i, sel_i, host_i, freeze_i, peak_i, obs_chk;
  logic [3:0] addr;
  logic wr_en, rd_chk, num_en;
  logic [15:0] wdata, rdata, disp, b, w, res16;
  logic [7:0] c;
  logic [19:0] conv_raw_i, res;
  logic [31:0] r;
  drp_seg_s seg;
  drp_note_s exp_q[$];
  drp_note_s n;
  logic [21:0] got;
  int error_cnt, compares;
  always #10 clk_i = ~clk_i;
  drp_host_model drp_host_model_inst (.clk_i(clk_i), .addr_o(addr), .wr_en_o(wr_en),
    .wdata_o(wdata), .rd_chk_o(rd_chk));
  drp_regs drp_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .clear_all_i(clear_all_i),
    .addr_i(addr), .wr_en_i(wr_en), .wdata_i(wdata), .rdata_o(rdata),
    .conv_valid_i(conv_valid_i), .conv_raw_i(conv_raw_i), .segment_override_select_i(sel_i),
    .display_source_host_i(host_i), .freeze_i(freeze_i), .peak_enable_i(peak_i),
    .seg_lit_o(seg), .numeric_enable_o(num_en), .display_value_o(disp));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic finish_test();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back({2'd0, 6'h00, e});
    drp_host_model_inst.rd(a);
  endtask
  // Outputs are judged after idle cycles so the register latency has settled
  task automatic look(input logic [1:0] s, input logic [21:0] e);
    repeat (3) @(posedge clk_i);
    #1;
    exp_q.push_back({s, e});
    obs_chk = 1'b1;
    @(posedge clk_i);
    #1;
    obs_chk = 1'b0;
  endtask
  task automatic conv(input logic [19:0] v);
    @(posedge clk_i);
    #1;
    conv_raw_i = v;
    conv_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    conv_valid_i = 1'b0;
    conv_raw_i = ~v;
  endtask
  always @(posedge clk_i) begin
    if (rd_chk === 1'b1 || obs_chk === 1'b1) begin
      #5;
      n = exp_q.pop_front();
      got = (n.sel == 2'd0) ? {6'h00, rdata} : (n.sel == 2'd1) ? seg : {5'h00, num_en, disp};
      compares++;
      if (got !== n.val) begin
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, n.val, got);
        error_cnt++;
      end
    end
  end
  initial begin
    #2_000_000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {clk_i, rst_n_i, clear_all_i, conv_valid_i, sel_i, host_i, freeze_i, peak_i} = 8'h00;
    obs_chk = 1'b0;
    conv_raw_i = 20'h0_0000;
    r = 32'hff7d_b0c2;
    repeat (4) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    for (int i = 0; i < 7; i++) rdchk(i[3:0], (i == 6) ? MAX_RST : 16'h0000);
    rdchk(4'hf, 16'h0000);
    $display("test reset done");
    r = lfsr(r);
    b = r[15:0];
    c = r[23:16];
    drp_host_model_inst.wr(IDX_SEG_B, b);
    drp_host_model_inst.wr(IDX_SEG_C, {8'h00, c});
    rdchk(IDX_SEG_B, b & SEG_B_WMASK);
    rdchk(IDX_SEG_C, {8'h00, c & SEG_C_WMASK});
    look(2'd1, 22'h00_0000);
    look(2'd2, {5'h00, 1'b1, 16'h0000});
    sel_i = 1'b1;
    look(2'd1, {~b[15:13], ~b[12], b[12], ~b[11:4], ~b[2:1],
      ~c[4:0], ~c[5], ~c[5]});
    look(2'd2, 22'h00_0000);
    sel_i = 1'b0;
    $display("test override done");
    drp_host_model_inst.wr(IDX_CONV_UP, 16'hffff);
    drp_host_model_inst.wr(IDX_CONV_LO, 16'hffff);
    drp_host_model_inst.wr(IDX_MAX, 16'h1234);
    drp_host_model_inst.wr(IDX_DISPLAY, 16'h5678);
    rdchk(IDX_CONV_UP, 16'h0000);
    rdchk(IDX_CONV_LO, 16'h0000);
    rdchk(IDX_MAX, MAX_RST);
    rdchk(IDX_DISPLAY, 16'h0000);
    $display("test read only done");
    r = lfsr(r);
    w = r[31:16];
    drp_host_model_inst.wr(IDX_OFFSET, w);
    rdchk(IDX_OFFSET, w);
    r = lfsr(r);
    conv(r[19:0]);
    res = r[19:0] - {w, 4'h0};
    rdchk(IDX_CONV_UP, res[19:4]);
    rdchk(IDX_CONV_LO, {8'h00, res[3:0], 4'h0});
    look(2'd2, {5'h00, 1'b1, res[19:4]});
    freeze_i = 1'b1;
    conv(~r[19:0]);
    rdchk(IDX_CONV_UP, 16'(({~r[19:0]} - {w, 4'h0}) >> 4));
    look(2'd2, {5'h00, 1'b1, res[19:4]});
    freeze_i = 1'b0;
    host_i = 1'b1;
    drp_host_model_inst.wr(IDX_DISPLAY, b);
    rdchk(IDX_DISPLAY, b);
    look(2'd2, {5'h00, 1'b1, b});
    host_i = 1'b0;
    $display("test conversion done");
    drp_host_model_inst.wr(IDX_OFFSET, 16'h0000);
    peak_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      conv((i == 0) ? 20'h8_0000 : (i == 1) ? 20'h0_1000 : 20'hf_f000);
      res16 = (i == 0) ? 16'h8000 : 16'h0100;
      rdchk(IDX_MAX, res16);
      look(2'd2, {5'h00, 1'b1, res16});
    end
    peak_i = 1'b0;
    rdchk(IDX_MAX, MAX_RST);
    $display("test peak done");
    drp_host_model_inst.wr(IDX_SEG_B, 16'hffff);
    @(posedge clk_i);
    #1;
    clear_all_i = 1'b1;
    @(posedge clk_i);
    #1;
    clear_all_i = 1'b0;
    rdchk(IDX_SEG_B, 16'h0000);
    rdchk(IDX_OFFSET, 16'h0000);
    rdchk(IDX_DISPLAY, 16'h0000);
    $display("test clear done");
    // A second reset in mid-run must restore the defaults as well
    drp_host_model_inst.wr(IDX_SEG_C, 16'h003f);
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    rdchk(IDX_SEG_C, 16'h0000);
    look(2'd2, {5'h00, 1'b1, 16'h0000});
    $display("test mid reset done");
    repeat (3) @(posedge clk_i);
    finish_test();
  end
endmodule // display_result_peak_regs_tb
